// >>> rtl/ipf_pkg.sv
package ipf_pkg;

    // Register bus geometry and priority field shape.
    localparam int NSRC    = 18;
    localparam int PRIO_W  = 3;
    localparam int REG_W   = 16;
    localparam int ADR_W   = 8;

    // Byte offsets of the registers on the bus.
    localparam logic [7:0] OFS_PRIO0  = 8'h00;
    localparam logic [7:0] OFS_PRIO1  = 8'h04;
    localparam logic [7:0] OFS_PRIO2  = 8'h08;
    localparam logic [7:0] OFS_PRIO3  = 8'h0C;
    localparam logic [7:0] OFS_PRIO4  = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_MASK   = 8'h1C;

    // Priority codes and reset values.
    localparam logic [2:0] PRIO_OFF   = 3'h0;
    localparam logic [2:0] PRIO_MIN   = 3'h1;
    localparam logic [2:0] PRIO_MAX   = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [NSRC-1:0] ENABLE_RESET = 18'h00000;
    localparam logic [NSRC-1:0] MASK_RESET   = 18'h00000;
    localparam logic [NSRC-1:0] STATUS_RESET = 18'h00000;

    // Source order: timer_one, compare_one, capture_one, ext_irq_zero,
    // timer_two, compare_two, capture_two, xfer_chan_zero,
    // serial_one_rx, sync_serial_one_event, sync_serial_one_error,
    // timer_three, xfer_chan_one, converter_one_done, serial_one_tx,
    // pin_change, twowire_one_master, twowire_one_slave.
    localparam logic [2:0] SRC_REG [NSRC] = '{
        3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2,
        3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4};
    localparam logic [3:0] SRC_LSB [NSRC] = '{
        4'hC, 4'h8, 4'h4, 4'h0, 4'hC, 4'h8, 4'h4, 4'h0, 4'hC,
        4'h8, 4'h4, 4'h0, 4'h8, 4'h4, 4'h0, 4'hC, 4'h4, 4'h0};

    // What the block presents to the core's arbitration.
    typedef struct packed {
        logic [NSRC-1:0]             req;
        logic [NSRC-1:0][PRIO_W-1:0] level;
        logic [PRIO_W-1:0]           top;
    } ipf_arb_t;

endpackage

// >>> rtl/ipf_bank.sv
`timescale 1ns/100ps
// Summary of operation
// - Field code 111 is level seven, the highest priority.
// - Code 001 is level one; codes one to seven map to equal levels.
// - Code 000 disables the source; it never requests.
// - Every field resets to 100, level four.
// - Unimplemented register bits read as zero.
// - Fields are read/write and hold the last written value.
// - Register 0: timer1 14-12, compare1 10-8, capture1 6-4, ext0 2-0.
// - Register 1: timer2 14-12, compare2 10-8, capture2 6-4, dma0 2-0.
// - Register 2: uart rx 14-12, spi event 10-8, spi err 6-4, timer3 2-0.
// - Register 3: 15-11 unused, dma1 10-8, adc 6-4, uart tx 2-0.
// - Register 4: change 14-12, 11-7 unused, i2c master 6-4, slave 2-0.
// - Enable one lets a request reach arbitration; zero blocks it.
module ipf_bank (
    input  wire logic                      clk,       // System clock.
    input  wire logic                      rst,       // Async reset.
    input  wire logic                      wb_cyc_i,  // Bus cycle.
    input  wire logic                      wb_stb_i,  // Bus strobe.
    input  wire logic                      wb_we_i,   // Write enable.
    input  wire logic [ipf_pkg::ADR_W-1:0] wb_adr_i,  // Byte address.
    input  wire logic [3:0]                wb_sel_i,  // Byte lanes.
    input  wire logic [31:0]               wb_dat_i,  // Write data.
    output logic      [31:0]               wb_dat_o,  // Read data.
    output logic                           wb_ack_o,  // Acknowledge.
    input  wire logic [ipf_pkg::NSRC-1:0]  src_req_i, // Source requests.
    output ipf_pkg::ipf_arb_t              arb_o,     // To arbitration.
    output logic                           irq_o      // Blocked-request irq.
);

    logic                                      ack_q;
    logic [31:0]                               dat_q;
    logic [31:0]                               dat_d;
    logic [ipf_pkg::NSRC-1:0][ipf_pkg::PRIO_W-1:0] prio_q;
    logic [ipf_pkg::NSRC-1:0]                  en_q;
    logic [ipf_pkg::NSRC-1:0]                  sts_q;
    logic [ipf_pkg::NSRC-1:0]                  sts_d;
    logic [ipf_pkg::NSRC-1:0]                  msk_q;
    logic [ipf_pkg::NSRC-1:0]                  req_q;
    logic [ipf_pkg::NSRC-1:0]                  live;
    logic [ipf_pkg::NSRC-1:0]                  armed;
    logic [ipf_pkg::NSRC-1:0]                  blocked;
    logic [ipf_pkg::NSRC-1:0]                  sts_clr;
    logic [ipf_pkg::PRIO_W-1:0]                top_q;
    logic                                      irq_q;
    logic                                      take;
    logic                                      wr;

    // A request is taken once; ack_q closes it in the following cycle.
    assign take = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr   = take && wb_we_i;

    // Byte address of one of the five priority registers.
    function automatic logic [ipf_pkg::ADR_W-1:0] prio_ofs(
        input logic [2:0] r
    );
        return ipf_pkg::OFS_PRIO0 + {3'h0, r, 2'b00};
    endfunction

    // Places each implemented field of register r; other bits stay zero.
    function automatic logic [ipf_pkg::REG_W-1:0] pack_reg(
        input logic [2:0]                                  r,
        input logic [ipf_pkg::NSRC-1:0][ipf_pkg::PRIO_W-1:0] p
    );
        logic [ipf_pkg::REG_W-1:0] v;
        v = '0;
        for (int i = 0; i < ipf_pkg::NSRC; i++) begin
            if (ipf_pkg::SRC_REG[i] == r) begin
                v[ipf_pkg::SRC_LSB[i] +: ipf_pkg::PRIO_W] = p[i];
            end
        end
        return v;
    endfunction

    // Each field sits wholly inside one byte lane.
    function automatic logic lane_on(
        input logic [3:0] lsb,
        input logic [3:0] sel
    );
        return lsb[3] ? sel[1] : sel[0];
    endfunction

    // Highest level among the sources that are presenting a request.
    function automatic logic [ipf_pkg::PRIO_W-1:0] top_of(
        input logic [ipf_pkg::NSRC-1:0]                    act,
        input logic [ipf_pkg::NSRC-1:0][ipf_pkg::PRIO_W-1:0] p
    );
        logic [ipf_pkg::PRIO_W-1:0] m;
        m = ipf_pkg::PRIO_OFF;
        for (int i = 0; i < ipf_pkg::NSRC; i++) begin
            if (act[i] && p[i] > m) begin
                m = p[i];
            end
        end
        return m;
    endfunction

    // Sources that may reach arbitration, and those being held back.
    always_comb begin
        for (int i = 0; i < ipf_pkg::NSRC; i++) begin
            armed[i] = prio_q[i] != ipf_pkg::PRIO_OFF;
        end
        live    = src_req_i & en_q & armed;
        blocked = src_req_i & ~(en_q & armed);
    end

    // Bus acknowledge: one cycle after the request is taken.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // Priority fields: byte-lane writes into the mapped positions.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ipf_pkg::NSRC; i++) begin
                prio_q[i] <= ipf_pkg::PRIO_RESET;
            end
        end else begin
            for (int i = 0; i < ipf_pkg::NSRC; i++) begin
                // Field map per register.
                // Sparse registers keep their holes.
                if (wr && wb_adr_i == prio_ofs(ipf_pkg::SRC_REG[i]) &&
                    lane_on(ipf_pkg::SRC_LSB[i], wb_sel_i)) begin
                    prio_q[i] <= wb_dat_i[ipf_pkg::SRC_LSB[i] +:
                                          ipf_pkg::PRIO_W];
                end
            end
        end
    end

    // Per-source enables, software controlled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= ipf_pkg::ENABLE_RESET;
        end else begin
            for (int b = 0; b < ipf_pkg::NSRC; b++) begin
                if (wr && wb_adr_i == ipf_pkg::OFS_ENABLE &&
                    wb_sel_i[b/8]) begin
                    en_q[b] <= wb_dat_i[b];
                end
            end
        end
    end

    // Interrupt mask, same layout as the status register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msk_q <= ipf_pkg::MASK_RESET;
        end else begin
            for (int b = 0; b < ipf_pkg::NSRC; b++) begin
                if (wr && wb_adr_i == ipf_pkg::OFS_MASK &&
                    wb_sel_i[b/8]) begin
                    msk_q[b] <= wb_dat_i[b];
                end
            end
        end
    end

    // Sticky blocked-request status; writing one clears, a new event wins.
    always_comb begin
        for (int b = 0; b < ipf_pkg::NSRC; b++) begin
            sts_clr[b] = wr && wb_adr_i == ipf_pkg::OFS_STATUS &&
                         wb_sel_i[b/8] && wb_dat_i[b];
        end
        sts_d = (sts_q & ~sts_clr) | blocked;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_q <= ipf_pkg::STATUS_RESET;
        end else begin
            sts_q <= sts_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_d & msk_q);
        end
    end

    // Requests and levels handed to the core's arbitration.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= '0;
            top_q <= ipf_pkg::PRIO_OFF;
        end else begin
            req_q <= live;
            top_q <= top_of(live, prio_q);
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        dat_d = 32'h0000_0000;
        case (wb_adr_i)
            ipf_pkg::OFS_PRIO0,
            ipf_pkg::OFS_PRIO1,
            ipf_pkg::OFS_PRIO2,
            ipf_pkg::OFS_PRIO3,
            ipf_pkg::OFS_PRIO4: begin
                // Register 4 keeps bits 11-7 empty.
                dat_d[15:0] = pack_reg(wb_adr_i[4:2], prio_q);
            end
            ipf_pkg::OFS_ENABLE: begin
                dat_d[ipf_pkg::NSRC-1:0] = en_q;
            end
            ipf_pkg::OFS_STATUS: begin
                dat_d[ipf_pkg::NSRC-1:0] = sts_q;
            end
            ipf_pkg::OFS_MASK: begin
                dat_d[ipf_pkg::NSRC-1:0] = msk_q;
            end
            default: begin
                dat_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_q <= 32'h0000_0000;
        end else if (take && !wb_we_i) begin
            dat_q <= dat_d;
        end else if (!take) begin
            dat_q <= 32'h0000_0000;
        end
    end

    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = dat_q;
    assign irq_o     = irq_q;
    assign arb_o.req   = req_q;
    assign arb_o.level = prio_q;
    assign arb_o.top   = top_q;

    property p_reset_default;
        @(posedge clk) disable iff (rst)
        $fell(rst) |->
            prio_q == {ipf_pkg::NSRC{ipf_pkg::PRIO_RESET}};
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("priority field not at level four after reset");

    property p_zero_blocks;
        @(posedge clk) disable iff (rst)
        (src_req_i[0] && prio_q[0] == 3'h0) |=> !req_q[0];
    endproperty
    a_zero_blocks: assert property (p_zero_blocks)
        else $error("disabled source presented a request");

    property p_enable_gates;
        @(posedge clk) disable iff (rst)
        ##1 (req_q & ~$past(src_req_i & en_q)) == '0 &&
            (!$past(src_req_i[0] && en_q[0] && prio_q[0] != 3'h0) ||
             req_q[0]);
    endproperty
    a_enable_gates: assert property (p_enable_gates)
        else $error("request did not follow enable and level");

    property p_top_level;
        @(posedge clk) disable iff (rst)
        (live[0] && prio_q[0] == 3'h7) |=> top_q == 3'h7;
    endproperty
    a_top_level: assert property (p_top_level)
        else $error("level seven request not reported as top");

    property p_level_one;
        @(posedge clk) disable iff (rst)
        (live == 18'h00001 && prio_q[0] == 3'h1) |=> top_q == 3'h1;
    endproperty
    a_level_one: assert property (p_level_one)
        else $error("level one request reported wrongly");

    property p_write_lands;
        @(posedge clk) disable iff (rst)
        (wr && wb_adr_i == 8'h00 && wb_sel_i == 4'hF) |=>
            arb_o.level[0] == $past(wb_dat_i[14:12]) &&
            arb_o.level[1] == $past(wb_dat_i[10:8]) &&
            arb_o.level[3] == $past(wb_dat_i[2:0]);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("register zero write not visible next clock");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !wr |=> $stable(prio_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("priority field changed without a write");

    property p_read_reg2;
        @(posedge clk) disable iff (rst)
        (take && !wb_we_i && wb_adr_i == 8'h08) |=>
            wb_ack_o && wb_dat_o[14:12] == $past(prio_q[8]) &&
            wb_dat_o[6:4] == $past(prio_q[10]) &&
            wb_dat_o[15] == 1'b0;
    endproperty
    a_read_reg2: assert property (p_read_reg2)
        else $error("register two read back wrong");

    property p_read_reg4;
        @(posedge clk) disable iff (rst)
        (take && !wb_we_i && wb_adr_i == 8'h10) |=>
            wb_dat_o[11:7] == 5'h00 && wb_dat_o[31:16] == 16'h0000 &&
            wb_dat_o[14:12] == $past(prio_q[15]);
    endproperty
    a_read_reg4: assert property (p_read_reg4)
        else $error("register four holes or field read wrong");

    property p_read_reg3;
        @(posedge clk) disable iff (rst)
        (take && !wb_we_i && wb_adr_i == 8'h0C) |=>
            wb_dat_o[15:11] == 5'h00 &&
            wb_dat_o[10:8] == $past(prio_q[12]);
    endproperty
    a_read_reg3: assert property (p_read_reg3)
        else $error("register three read back wrong");

    property p_write_reg1;
        @(posedge clk) disable iff (rst)
        (wr && wb_adr_i == 8'h04 && wb_sel_i[0]) |=>
            prio_q[6] == $past(wb_dat_i[6:4]) &&
            prio_q[7] == $past(wb_dat_i[2:0]);
    endproperty
    a_write_reg1: assert property (p_write_reg1)
        else $error("register one low fields not written");

    property p_ack_once;
        @(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("acknowledge held longer than one cycle");

    property p_live_next;
        @(posedge clk) disable iff (rst)
        (wr && wb_adr_i == 8'h00 && wb_sel_i[1] &&
         wb_dat_i[14:12] == 3'h0) |=> ##1 !req_q[0];
    endproperty
    a_live_next: assert property (p_live_next)
        else $error("zeroed source still requesting after write");

    property p_irq;
        @(posedge clk) disable iff (rst)
        $stable(msk_q) |-> irq_o == |(sts_q & msk_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with status and mask");

endmodule

// >>> tb/ipf_src_model.sv
`timescale 1ns/100ps
module ipf_src_model (
    input  wire logic                     clk,     // System clock.
    input  wire logic                     rst,     // Async reset.
    input  wire logic [ipf_pkg::NSRC-1:0] want,    // Levels asked by bench.
    output logic      [ipf_pkg::NSRC-1:0] src_req  // Requests to the block.
);
    // Peripheral sources change their request levels only on a clock edge.
    // They stay quiet through reset, so no request precedes its release.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_req <= '0;
        end else begin
            src_req <= want;
        end
    end
endmodule

// >>> tb/test_interrupt_priority_field_bank.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        mismatches++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module test_interrupt_priority_field_bank;
    logic                     clk = 1'b0;
    logic                     rst;
    logic                     cyc;
    logic                     stb;
    logic                     we;
    logic [7:0]               adr;
    logic [3:0]               sel;
    logic [31:0]              wdat;
    logic [31:0]              rdat;
    logic                     ack;
    logic                     irq;
    logic [ipf_pkg::NSRC-1:0] want;
    logic [ipf_pkg::NSRC-1:0] src_req;
    ipf_pkg::ipf_arb_t        arb;
    logic [31:0]              q;
    int                       mismatches = 0;
    int                       samples_checked = 0;
    localparam logic [15:0] RST_EXP [5] = '{16'h4444, 16'h4444, 16'h4444,
                                            16'h0444, 16'h4044};

    always #5 clk = ~clk;

    ipf_bank ipf_bank_i (
        .clk       (clk),
        .rst       (rst),
        .wb_cyc_i  (cyc),
        .wb_stb_i  (stb),
        .wb_we_i   (we),
        .wb_adr_i  (adr),
        .wb_sel_i  (sel),
        .wb_dat_i  (wdat),
        .wb_dat_o  (rdat),
        .wb_ack_o  (ack),
        .src_req_i (src_req),
        .arb_o     (arb),
        .irq_o     (irq)
    );

    ipf_src_model ipf_src_model_i (
        .clk     (clk),
        .rst     (rst),
        .want    (want),
        .src_req (src_req)
    );

    task automatic give_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One classic cycle; held until ack is sampled high, data taken there.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      input logic [3:0] s = 4'hF);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic t_reset;
        for (int r = 0; r < 5; r++) begin
            wb(1'b0, 8'(r * 4), 32'h0, q);
            `CHK("reset value", {16'h0, RST_EXP[r]}, q)
        end
        for (int i = 0; i < ipf_pkg::NSRC; i++) begin
            `CHK("reset level", 3'h4, arb.level[i])
        end
    endtask

    task automatic t_map;
        logic [2:0] fx;
        for (int r = 0; r < 5; r++) begin
            wb(1'b1, 8'(r * 4), 32'hFFFF_F5A3, q);
        end
        wb(1'b0, ipf_pkg::OFS_PRIO0, 32'h0, q);
        `CHK("map reg0", 32'h0000_7523, q)
        wb(1'b0, ipf_pkg::OFS_PRIO1, 32'h0, q);
        `CHK("map reg1", 32'h0000_7523, q)
        wb(1'b0, ipf_pkg::OFS_PRIO2, 32'h0, q);
        `CHK("map reg2", 32'h0000_7523, q)
        wb(1'b0, ipf_pkg::OFS_PRIO3, 32'h0, q);
        `CHK("map reg3", 32'h0000_0523, q)
        wb(1'b0, ipf_pkg::OFS_PRIO4, 32'h0, q);
        `CHK("map reg4", 32'h0000_7023, q)
        for (int i = 0; i < ipf_pkg::NSRC; i++) begin
            fx = 3'(16'hF5A3 >> ipf_pkg::SRC_LSB[i]);
            `CHK("field map", fx, arb.level[i])
        end
        // Only the low byte lane is enabled, so the upper fields keep.
        wb(1'b1, ipf_pkg::OFS_PRIO0, 32'h0, q, 4'h1);
        wb(1'b0, ipf_pkg::OFS_PRIO0, 32'h0, q);
        `CHK("lane write", 32'h0000_7500, q)
        wb(1'b1, 8'h20, 32'hFFFF_FFFF, q);
        wb(1'b0, 8'h20, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
    endtask

    task automatic t_codes;
        wb(1'b1, ipf_pkg::OFS_ENABLE, 32'h1, q);
        wb(1'b1, ipf_pkg::OFS_MASK, 32'h1, q);
        @(posedge clk);
        want <= 18'h00001;
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, ipf_pkg::OFS_PRIO0, 32'(c) << 12, q);
            `CHK("level now", 3'(c), arb.level[0])
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK("req", c != 0, arb.req[0])
            `CHK("top", 3'(c), arb.top)
        end
        `CHK("irq set", 1'b1, irq)
        wb(1'b1, ipf_pkg::OFS_ENABLE, 32'h0, q);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("blocked", 1'b0, arb.req[0])
        `CHK("blocked top", 3'h0, arb.top)
        wb(1'b1, ipf_pkg::OFS_STATUS, 32'h1, q);
        wb(1'b0, ipf_pkg::OFS_STATUS, 32'h0, q);
        `CHK("event wins", 32'h1, q)
        wb(1'b1, ipf_pkg::OFS_MASK, 32'h0, q);
        @(negedge clk);
        `CHK("masked", 1'b0, irq)
        @(posedge clk);
        want <= '0;
        wb(1'b1, ipf_pkg::OFS_STATUS, 32'h1, q);
        wb(1'b0, ipf_pkg::OFS_STATUS, 32'h0, q);
        `CHK("cleared", 32'h0, q)
        wb(1'b1, ipf_pkg::OFS_MASK, 32'h1, q);
        @(negedge clk);
        `CHK("irq low", 1'b0, irq)
    endtask

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        want = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_map();
        t_codes();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule
